//--- anim_bank_cfg.svh
`ifndef ANIM_BANK_CFG_SVH
`define ANIM_BANK_CFG_SVH

// ============================================================
// register offsets
`define OFS_PAUSE        8'h9A
`define OFS_PLAYBACK     8'h9B
`define OFS_U1_LEVEL1    8'h9C
`define OFS_U1_LEVEL2    8'h9D
`define OFS_U1_LEVEL3    8'h9E
`define OFS_U1_LEVEL4    8'h9F
`define OFS_U1_LEVEL5    8'hA0
`define OFS_U1_SLOPES12  8'hA1
`define OFS_U1_SLOPES34  8'hA2
`define OFS_U1_REPEAT    8'hA3
`define OFS_U2_LEVEL1    8'hA4
`define OFS_U2_LEVEL2    8'hA5
`define OFS_U2_LEVEL3    8'hA6
`define OFS_U2_LEVEL4    8'hA7
`define OFS_U2_LEVEL5    8'hA8
`define OFS_CTRL         8'hC0
`define OFS_STATUS       8'hC1
`define OFS_DUTY         8'hC2

// ============================================================
// fields, reset values, write masks
`define CTRL_START_BIT   0
`define CTRL_STOP_BIT    1
`define PAUSE_START_LSB  4
`define PAUSE_END_LSB    0
`define UNIT_NUM_LSB     4
`define PATTERN_FOREVER  4'hF
`define UNIT_FOREVER     2'h3
`define REG_RESET        8'h00
`define PLAYBACK_WMASK   8'h3F
`define U1_REPEAT_WMASK  8'h03

// ============================================================
// timing: table in hundredths of a second, code 0 at the low end
`define CLK_PERIOD_NS    100
`define TICK_TIME_MS     10
`define TICK_CYCLES      ((`TICK_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define TIME_TABLE_CS    {10'd805, 10'd706, 10'd599, 10'd501, 10'd402, 10'd304, 10'd250, 10'd206, \
                          10'd152, 10'd107, 10'd80, 10'd54, 10'd36, 10'd18, 10'd9, 10'd0}

`endif

//--- anim_bank_pkg.sv
`default_nettype none

package anim_bank_pkg;

	typedef enum logic [2:0]
	{
		S_IDLE        = 3'b000,
		S_START_PAUSE = 3'b001,
		S_NEXT        = 3'b010,
		S_SLOPE       = 3'b011,
		S_END_PAUSE   = 3'b100
	} eng_state_t;

	typedef struct packed
	{
		logic [14:0][7:0] regs;
		logic [7:0]       rdata;
		eng_state_t       st;
		logic             unit;
		logic [1:0]       seg;
		logic [1:0]       unit_left;
		logic [3:0]       pat_left;
		logic [7:0]       duty;
	} bank_state_t;

	typedef struct packed
	{
		logic        busy;
		logic        done;
		logic        tick;
		logic [31:0] pre;
		logic [9:0]  ticks;
	} timer_state_t;

endpackage : anim_bank_pkg

`default_nettype wire

//--- segment_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "anim_bank_cfg.svh"

module segment_timer
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
)
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// request
	input  wire logic       start,
	input  wire logic [3:0] code,
	// progress
	output logic            tick,
	output logic            done,
	output logic            busy
);

	localparam logic [31:0] PRE_LAST = 32'(TICK_CYCLES - 1);
	localparam logic [159:0] TIME_TABLE = `TIME_TABLE_CS;

	anim_bank_pkg::timer_state_t s_reg;
	anim_bank_pkg::timer_state_t s_next;

	// ============================================================
	// code to duration
	function automatic logic [9:0] ticks_of(input logic [3:0] c);
		ticks_of = TIME_TABLE[c * 10 +: 10];
	endfunction : ticks_of

	// ============================================================
	// countdown; a fresh start always overrides a running count
	always_comb
	begin
		s_next      = s_reg;
		s_next.done = 1'b0;
		s_next.tick = 1'b0;
		if (start)
		begin
			s_next.busy  = 1'b1;
			s_next.ticks = ticks_of(code);
			s_next.pre   = 32'h0000_0000;
		end
		else if (s_reg.busy)
		begin
			if (s_reg.ticks == 10'h000)
			begin
				s_next.busy = 1'b0;
				s_next.done = 1'b1;
			end
			else if (s_reg.pre == PRE_LAST)
			begin
				s_next.pre   = 32'h0000_0000;
				s_next.ticks = s_reg.ticks - 10'h001;
				s_next.tick  = 1'b1;
			end
			else
			begin
				s_next.pre = s_reg.pre + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign tick = s_reg.tick;
	assign done = s_reg.done;
	assign busy = s_reg.busy;

endmodule : segment_timer
`default_nettype wire

//--- anim_config_bank.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "anim_bank_cfg.svh"

module anim_config_bank
#(
	parameter int TICK_CYCLES = `TICK_CYCLES
)
(
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	// register port
	input  wire logic [7:0]  ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [7:0]  RDATA,
	// unit two timing held in the neighbouring bank
	input  wire logic [15:0] U2_SLOPES,
	input  wire logic [1:0]  U2_REPEAT,
	// engine outputs
	output logic      [7:0]  DUTY,
	output logic             ENGINE_BUSY,
	output logic      [1:0]  ACTIVE_UNITS
);

	localparam logic [3:0] I_PAUSE = 4'(`OFS_PAUSE - `OFS_PAUSE);
	localparam logic [3:0] I_PB    = 4'(`OFS_PLAYBACK - `OFS_PAUSE);
	localparam logic [3:0] I_U1L1  = 4'(`OFS_U1_LEVEL1 - `OFS_PAUSE);
	localparam logic [3:0] I_U1S12 = 4'(`OFS_U1_SLOPES12 - `OFS_PAUSE);
	localparam logic [3:0] I_U1S34 = 4'(`OFS_U1_SLOPES34 - `OFS_PAUSE);
	localparam logic [3:0] I_U1RP  = 4'(`OFS_U1_REPEAT - `OFS_PAUSE);
	localparam logic [3:0] I_U2L1  = 4'(`OFS_U2_LEVEL1 - `OFS_PAUSE);

	anim_bank_pkg::bank_state_t st_reg;
	anim_bank_pkg::bank_state_t st_next;

	logic        cmd_start;
	logic        cmd_stop;
	logic        timer_start;
	logic [3:0]  timer_code;
	logic        t_tick;
	logic        t_done;
	logic [4:0]  hit_idx;
	logic [7:0]  target;

	// ============================================================
	// decode helpers
	function automatic logic [4:0] map_addr(input logic [7:0] a);
		logic [7:0] d;
		d = a - `OFS_PAUSE;
		map_addr = {(a >= `OFS_PAUSE) && (a <= `OFS_U2_LEVEL5), d[3:0]};
	endfunction : map_addr

	function automatic logic [7:0] wmask(input logic [3:0] idx);
		if (idx == I_PB)
			wmask = `PLAYBACK_WMASK;
		else if (idx == I_U1RP)
			wmask = `U1_REPEAT_WMASK;
		else
			wmask = 8'hFF;
	endfunction : wmask

	function automatic logic [1:0] units_of(input logic [1:0] code);
		if (code == 2'h0)
			units_of = 2'h1;
		else if (code == 2'h1)
			units_of = 2'h2;
		else
			units_of = 2'h3;
	endfunction : units_of

	function automatic logic [7:0] level_of(input logic [14:0][7:0] r, input logic u, input logic [2:0] k);
		level_of = r[(u ? I_U2L1 : I_U1L1) + 4'(k)];
	endfunction : level_of

	function automatic logic [3:0] slope_of(input logic [14:0][7:0] r, input logic [15:0] ext, input logic u,
		input logic [1:0] sg);
		logic [15:0] all;
		all = u ? ext : {r[I_U1S34], r[I_U1S12]};
		slope_of = all[sg * 4 +: 4];
	endfunction : slope_of

	// ============================================================
	// time base for pauses and slopes
	segment_timer
	#(
		.TICK_CYCLES (TICK_CYCLES)
	)
	u_timer
	(
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.start (timer_start),
		.code  (timer_code),
		.tick  (t_tick),
		.done  (t_done),
		.busy  ()
	);

	// ============================================================
	// register port and engine
	always_comb
	begin
		st_next     = st_reg;
		cmd_start   = 1'b0;
		cmd_stop    = 1'b0;
		timer_start = 1'b0;
		timer_code  = 4'h0;
		hit_idx     = map_addr(ADDR);
		target      = level_of(st_reg.regs, st_reg.unit, 3'(st_reg.seg) + 3'h1);
		// read data stands for one cycle only
		st_next.rdata = 8'h00;

		if (WR)
		begin
			if (hit_idx[4])
				st_next.regs[hit_idx[3:0]] = WDATA & wmask(hit_idx[3:0]);
			else if (ADDR == `OFS_CTRL)
			begin
				cmd_start = WDATA[`CTRL_START_BIT];
				cmd_stop  = WDATA[`CTRL_STOP_BIT];
			end
		end
		if (RD)
		begin
			if (hit_idx[4])
				st_next.rdata = st_reg.regs[hit_idx[3:0]];
			else if (ADDR == `OFS_STATUS)
				st_next.rdata = {st_reg.st, st_reg.unit, st_reg.seg, 1'b0, (st_reg.st != anim_bank_pkg::S_IDLE)};
			else if (ADDR == `OFS_DUTY)
				st_next.rdata = st_reg.duty;
		end

		case (st_reg.st)
			anim_bank_pkg::S_IDLE:
			begin
				// zero repetitions: a start leaves the engine idle
				if (cmd_start && (st_reg.regs[I_PB][3:0] != 4'h0))
				begin
					st_next.pat_left = st_reg.regs[I_PB][3:0];
					timer_start      = 1'b1;
					timer_code       = st_reg.regs[I_PAUSE][`PAUSE_START_LSB +: 4];
					st_next.st       = anim_bank_pkg::S_START_PAUSE;
				end
			end
			anim_bank_pkg::S_START_PAUSE:
			begin
				if (t_done)
				begin
					st_next.unit      = 1'b0;
					st_next.unit_left = st_reg.regs[I_U1RP][1:0];
					st_next.st        = anim_bank_pkg::S_NEXT;
				end
			end
			anim_bank_pkg::S_NEXT:
			begin
				if (st_reg.unit_left == 2'h0)
				begin
					// units run in order; unit two only when the count field allows it
					if (!st_reg.unit && (units_of(st_reg.regs[I_PB][`UNIT_NUM_LSB +: 2]) != 2'h1))
					begin
						st_next.unit      = 1'b1;
						st_next.unit_left = U2_REPEAT;
					end
					else
					begin
						timer_start = 1'b1;
						timer_code  = st_reg.regs[I_PAUSE][`PAUSE_END_LSB +: 4];
						st_next.st  = anim_bank_pkg::S_END_PAUSE;
					end
				end
				else
				begin
					st_next.seg  = 2'h0;
					st_next.duty = level_of(st_reg.regs, st_reg.unit, 3'h0);
					timer_start  = 1'b1;
					timer_code   = slope_of(st_reg.regs, U2_SLOPES, st_reg.unit, 2'h0);
					st_next.st   = anim_bank_pkg::S_SLOPE;
				end
			end
			anim_bank_pkg::S_SLOPE:
			begin
				if (t_done)
				begin
					// land exactly on the level whatever the step count was
					st_next.duty = target;
					if (st_reg.seg == 2'h3)
					begin
						if (st_reg.unit_left != `UNIT_FOREVER)
							st_next.unit_left = st_reg.unit_left - 2'h1;
						st_next.st = anim_bank_pkg::S_NEXT;
					end
					else
					begin
						st_next.seg = st_reg.seg + 2'h1;
						timer_start = 1'b1;
						timer_code  = slope_of(st_reg.regs, U2_SLOPES, st_reg.unit, st_reg.seg + 2'h1);
					end
				end
				else if (t_tick)
				begin
					// one code step per tick; long slopes end flat, short ones snap
					if (st_reg.duty < target)
						st_next.duty = st_reg.duty + 8'h01;
					else if (st_reg.duty > target)
						st_next.duty = st_reg.duty - 8'h01;
				end
			end
			anim_bank_pkg::S_END_PAUSE:
			begin
				if (t_done)
				begin
					if (st_reg.pat_left == 4'h1)
						st_next.st = anim_bank_pkg::S_IDLE;
					else
					begin
						if (st_reg.pat_left != `PATTERN_FOREVER)
							st_next.pat_left = st_reg.pat_left - 4'h1;
						timer_start = 1'b1;
						timer_code  = st_reg.regs[I_PAUSE][`PAUSE_START_LSB +: 4];
						st_next.st  = anim_bank_pkg::S_START_PAUSE;
					end
				end
			end
			default:
			begin
				st_next.st = anim_bank_pkg::S_IDLE;
			end
		endcase

		if (cmd_stop)
			st_next.st = anim_bank_pkg::S_IDLE;
	end

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			st_reg      <= '0;
			st_reg.regs <= {15{`REG_RESET}};
		end
		else
			st_reg <= st_next;
	end

	assign RDATA        = st_reg.rdata;
	assign DUTY         = st_reg.duty;
	assign ENGINE_BUSY  = (st_reg.st != anim_bank_pkg::S_IDLE);
	assign ACTIVE_UNITS = units_of(st_reg.regs[I_PB][`UNIT_NUM_LSB +: 2]);

	// ============================================================
	// checks
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);

	logic [15:0] u1_slopes;
	assign u1_slopes = {st_reg.regs[I_U1S34], st_reg.regs[I_U1S12]};

	AST_RESET_CLEAR: assert property ($rose(RST_N) |-> (st_reg.regs == '0) && (DUTY == 8'h00) && !ENGINE_BUSY)
		else $error("bank not cleared by reset");

	AST_PLAYBACK_MASK: assert property ((WR && (ADDR == `OFS_PLAYBACK))
		|=> st_reg.regs[I_PB] == ($past(WDATA) & 8'h3F))
		else $error("playback write not masked");

	AST_RSVD_ZERO: assert property ((st_reg.regs[I_PB][7:6] == 2'b00) && (st_reg.regs[I_U1RP][7:2] == 6'h00))
		else $error("reserved bits not zero");

	AST_LEVEL_READBACK: assert property ((RD && (ADDR == `OFS_U1_LEVEL1))
		|=> (RDATA == $past(st_reg.regs[I_U1L1])) ##1 (RDATA == 8'h00 || $past(RD)))
		else $error("level read back wrong");

	AST_U2_LEVEL_WRITE: assert property ((WR && (ADDR == `OFS_U2_LEVEL5))
		|=> (st_reg.regs[14] == $past(WDATA)))
		else $error("unit two level not stored");

	AST_START_PAUSE_CODE: assert property ((timer_start && (st_next.st == anim_bank_pkg::S_START_PAUSE))
		|-> timer_code == st_reg.regs[I_PAUSE][7:4])
		else $error("start pause code wrong");

	AST_END_PAUSE_CODE: assert property ((timer_start && (st_next.st == anim_bank_pkg::S_END_PAUSE))
		|-> timer_code == st_reg.regs[I_PAUSE][3:0])
		else $error("end pause code wrong");

	AST_UNIT2_GATED: assert property ((st_reg.st == anim_bank_pkg::S_SLOPE) && st_reg.unit
		|-> st_reg.regs[I_PB][5:4] != 2'b00)
		else $error("unit two ran while one unit selected");

	AST_PATTERN_ZERO: assert property ((st_reg.st == anim_bank_pkg::S_IDLE) && cmd_start
		&& (st_reg.regs[I_PB][3:0] == 4'h0) |=> !ENGINE_BUSY [*2])
		else $error("zero repetitions started the engine");

	AST_PATTERN_FOREVER: assert property ((st_reg.st == anim_bank_pkg::S_END_PAUSE) && t_done && !cmd_stop
		&& (st_reg.pat_left == 4'hF) |=> (st_reg.st == anim_bank_pkg::S_START_PAUSE) && (st_reg.pat_left == 4'hF))
		else $error("endless pattern stopped");

	AST_U1_SLOPE_CODE: assert property ((timer_start && (st_next.st == anim_bank_pkg::S_SLOPE) && !st_reg.unit)
		|-> timer_code == u1_slopes[st_next.seg * 4 +: 4])
		else $error("unit one slope code wrong");

	AST_U1_SLOPE4_CODE: assert property ((timer_start && !st_reg.unit && (st_reg.st == anim_bank_pkg::S_SLOPE)
		&& (st_reg.seg == 2'h2)) |-> timer_code == st_reg.regs[I_U1S34][7:4])
		else $error("unit one fourth slope code wrong");

	AST_U1_SKIP: assert property ((st_reg.st == anim_bank_pkg::S_NEXT) && !st_reg.unit && !cmd_stop
		&& (st_reg.unit_left == 2'h0) |=> (st_reg.st != anim_bank_pkg::S_SLOPE) || st_reg.unit)
		else $error("unit one played with zero count");

	AST_SEG_SNAP: assert property ((st_reg.st == anim_bank_pkg::S_SLOPE) && t_done && !cmd_stop
		|=> DUTY == $past(target))
		else $error("segment did not end on its level");

	COV_PATTERN_DONE: cover property ((st_reg.st == anim_bank_pkg::S_END_PAUSE) ##1 (st_reg.st == anim_bank_pkg::S_IDLE));
	COV_UNIT2_RUN: cover property ((st_reg.st == anim_bank_pkg::S_SLOPE) && st_reg.unit);
	COV_FOREVER: cover property ((st_reg.pat_left == 4'hF) && (st_reg.st == anim_bank_pkg::S_START_PAUSE));

endmodule : anim_config_bank
`default_nettype wire

//--- tb_anim_config_bank.sv
`timescale 1ns/1ns
`default_nettype none

module tb_anim_config_bank;

	// ============================================================
	// signals
	localparam int TICKS = 4;
	logic        REF_CLK   = 1'b0;
	logic        RST_N     = 1'b0;
	logic [7:0]  ADDR      = 8'h00;
	logic [7:0]  WDATA     = 8'h00;
	logic        WR        = 1'b0;
	logic        RD        = 1'b0;
	logic [15:0] U2_SLOPES = 16'h0000;
	logic [1:0]  U2_REPEAT = 2'h0;
	logic [7:0]  RDATA;
	logic [7:0]  DUTY;
	logic        ENGINE_BUSY;
	logic [1:0]  ACTIVE_UNITS;
	logic [7:0]  exp_q [$];
	logic [7:0]  shadow [15];
	logic        rd_seen   = 1'b0;
	int          n_fail    = 0;
	int          compares  = 0;
	int          seed      = 32'h4d03_e2cf;
	int          n;

	anim_config_bank #(.TICK_CYCLES(TICKS)) dut_u
	(
		.REF_CLK      (REF_CLK),
		.RST_N        (RST_N),
		.ADDR         (ADDR),
		.WDATA        (WDATA),
		.WR           (WR),
		.RD           (RD),
		.RDATA        (RDATA),
		.U2_SLOPES    (U2_SLOPES),
		.U2_REPEAT    (U2_REPEAT),
		.DUTY         (DUTY),
		.ENGINE_BUSY  (ENGINE_BUSY),
		.ACTIVE_UNITS (ACTIVE_UNITS)
	);

	always #50 REF_CLK = ~REF_CLK;

	// ============================================================
	// reporting
	task finish_test;
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	task chk_rd(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %0t read data %h expected %h", $time, got, exp);
		end
	endtask : chk_rd

	task chk_val(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %0t output %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	// ============================================================
	// read data watcher: oldest note per answered read
	always @(posedge REF_CLK)
	begin
		if (rd_seen && exp_q.size() > 0)
			chk_rd(RDATA, exp_q.pop_front());
		else if (RST_N)
			chk_rd(RDATA, 8'h00);
		rd_seen <= RD && RST_N;
	end

	// ============================================================
	// bus tasks, entered just after a rising edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		ADDR  <= a;
		WDATA <= d;
		WR    <= 1'b1;
		RD    <= 1'b0;
		@(posedge REF_CLK);
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		ADDR <= a;
		RD   <= 1'b1;
		WR   <= 1'b0;
		exp_q.push_back(e);
		@(posedge REF_CLK);
	endtask : rd

	task idle(input int cyc);
		WR <= 1'b0;
		RD <= 1'b0;
		repeat (cyc) @(posedge REF_CLK);
	endtask : idle

	task do_reset;
		RST_N <= 1'b0;
		idle(10);
		RST_N <= 1'b1;
		@(posedge REF_CLK);
	endtask : do_reset

	task start_engine;
		wr(8'hC0, 8'h01);
		idle(0);
	endtask : start_engine

	// busy is only settled once the edge's updates are in, so look off the edge
	task wait_idle(input int lim);
		n = 0;
		#1;
		while (ENGINE_BUSY === 1'b1 && n < lim)
		begin
			@(posedge REF_CLK);
			#1;
			n++;
		end
	endtask : wait_idle

	// reserved bits of the repeat registers never store
	function automatic logic [7:0] wmask(input int i);
		return (i == 1) ? 8'h3F : (i == 9) ? 8'h03 : 8'hFF;
	endfunction : wmask

	// ============================================================
	// watchdog
	initial
	begin
		repeat (10000) @(posedge REF_CLK);
		n_fail++;
		finish_test();
	end

	// ============================================================
	// main sequence
	initial
	begin
		do_reset();
		U2_SLOPES <= 16'($random(seed));
		U2_REPEAT <= 2'($random(seed));
		chk_val({6'h00, ACTIVE_UNITS}, 8'h01);
		for (int i = 0; i < 15; i++)
			rd(8'h9A + 8'(i), 8'h00);
		for (int i = 0; i < 15; i++)
		begin
			shadow[i] = 8'($random(seed));
			wr(8'h9A + 8'(i), shadow[i]);
		end
		wr(8'hA9, 8'h5A);
		for (int i = 0; i < 15; i++)
			rd(8'h9A + 8'(i), shadow[i] & wmask(i));
		rd(8'hA9, 8'h00);
		rd(8'h99, 8'h00);
		idle(3);
		// second reset after writes brings every byte back to zero
		do_reset();
		for (int i = 0; i < 15; i++)
			rd(8'h9A + 8'(i), 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h9B, {2'h0, 2'(k), 4'h1});
			idle(1);
			#1;
			chk_val({6'h00, ACTIVE_UNITS}, (k == 0) ? 8'h01 : (k == 1) ? 8'h02 : 8'h03);
		end
		// start pause code 3, end code 0, ramp 00h -> FFh on slope one
		wr(8'h9A, 8'h30);
		wr(8'h9B, 8'h00);
		wr(8'h9C, 8'h00);
		for (int i = 0; i < 4; i++)
			wr(8'h9D + 8'(i), 8'hFF);
		wr(8'hA1, 8'h01);
		wr(8'hA2, 8'h00);
		wr(8'hA3, 8'h01);
		start_engine();
		idle(3);
		#1;
		chk_val({7'h00, ENGINE_BUSY}, 8'h00);
		wr(8'h9B, 8'h01);
		start_engine();
		#1;
		chk_val({7'h00, ENGINE_BUSY}, 8'h01);
		// 36 ticks of 4 cycles plus 2 before the ramp may move
		n = 1;
		while (DUTY === 8'h00 && n < 400)
		begin
			@(posedge REF_CLK);
			#1;
			n++;
		end
		chk_val({7'h00, n >= 146 && n <= 160}, 8'h01);
		wait_idle(2000);
		chk_val({7'h00, ENGINE_BUSY}, 8'h00);
		// short pattern: fourteen plays end, code F and unit code 3 do not
		wr(8'h9A, 8'h00);
		wr(8'hA1, 8'h00);
		wr(8'h9B, 8'h0E);
		start_engine();
		wait_idle(1000);
		chk_val({7'h00, ENGINE_BUSY}, 8'h00);
		chk_val(DUTY, 8'hFF);
		// two units: unit two runs after unit one and leaves its last level
		U2_REPEAT <= 2'h1;
		U2_SLOPES <= 16'($random(seed)) & 16'h1111;
		wr(8'hA8, 8'h5A);
		wr(8'h9B, 8'h11);
		start_engine();
		wait_idle(1000);
		chk_val(DUTY, 8'h5A);
		rd(8'hC2, 8'h5A);
		rd(8'hC1, 8'h1C);
		for (int k = 0; k < 2; k++)
		begin
			wr(8'h9B, (k == 0) ? 8'h0F : 8'h01);
			wr(8'hA3, (k == 0) ? 8'h01 : 8'h03);
			start_engine();
			idle(600);
			#1;
			chk_val({7'h00, ENGINE_BUSY}, 8'h01);
			wr(8'hC0, 8'h02);
			idle(3);
			#1;
			chk_val({7'h00, ENGINE_BUSY}, 8'h00);
		end
		idle(2);
		finish_test();
	end

endmodule : tb_anim_config_bank

`default_nettype wire
